// ### ebcu_pkg.sv
// Shared types and constants for the external bus cycle unit
package ebcu_pkg;

    // Data path width of a chip-select region
    typedef enum logic [1:0] {
        EBCU_W32,
        EBCU_W8,
        EBCU_W16
    } ebcu_width_t;

    // Bus sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_WAIT,
        S_TURN,
        S_GRANT
    } ebcu_state_t;

    // Access size from the core
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Region width code, {hi, lo}
    localparam logic [1:0] CODE_W32 = 2'h0;
    localparam logic [1:0] CODE_W8 = 2'h1;
    localparam logic [1:0] CODE_W16 = 2'h2;

    // Boot width straps, {half, byte}
    localparam logic [1:0] STRAP_W16 = 2'h1;
    localparam logic [1:0] STRAP_W8 = 2'h2;
    localparam logic [1:0] STRAP_W32 = 2'h3;

    // Region numbers with special meaning
    localparam logic [2:0] REGION_BOOT = 3'h0;
    localparam logic [2:0] REGION_DRAM_A = 3'h4;
    localparam logic [2:0] REGION_DRAM_B = 3'h5;
    localparam int REGION_COUNT = 6;

    // Last beat index of a four-word burst
    localparam logic [1:0] BURST_LAST = 2'h3;

    // Internal wait-state generator delay
    localparam int CLK_PERIOD_NS = 50;
    localparam int WS_TIME_NS = 100;
    localparam logic [2:0] WS_CYCLES = 3'((WS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Reset values
    localparam logic [27:0] ADDR_RST = 28'h0000000;
    localparam logic [31:0] DATA_RST = 32'h00000000;
    localparam logic [3:0] BE_RST = 4'hF;

endpackage : ebcu_pkg

// ### ebcu_width_dec.sv
// Decoder from a two-bit width code or strap pair to a region width
`timescale 1ns/10ps
module ebcu_width_dec #(
    parameter bit STRAP = 1'b0
) (
    // Code in
    input wire logic [1:0] code,
    // Decoded width
    output ebcu_pkg::ebcu_width_t width,
    output logic illegal
);

    // Illegal codes fall back to 32-bit so the bus still moves whole words
    always_comb begin
        width = ebcu_pkg::EBCU_W32;
        illegal = 1'b0;
        if (STRAP) begin
            case (code)
                ebcu_pkg::STRAP_W16: width = ebcu_pkg::EBCU_W16;
                ebcu_pkg::STRAP_W8: width = ebcu_pkg::EBCU_W8;
                ebcu_pkg::STRAP_W32: width = ebcu_pkg::EBCU_W32;
                default: illegal = 1'b1;
            endcase
        end else begin
            case (code)
                ebcu_pkg::CODE_W32: width = ebcu_pkg::EBCU_W32;
                ebcu_pkg::CODE_W8: width = ebcu_pkg::EBCU_W8;
                ebcu_pkg::CODE_W16: width = ebcu_pkg::EBCU_W16;
                default: illegal = 1'b1;
            endcase
        end
    end

endmodule : ebcu_width_dec

// ### ebcu_lane_steer.sv
// Byte lane enable steering for one bus beat
`timescale 1ns/10ps
module ebcu_lane_steer (
    // Beat description
    input ebcu_pkg::ebcu_width_t width,
    input wire logic rd,
    input wire logic [1:0] size,
    input wire logic [1:0] lo,
    // Lane enables, active low where they are enables
    output logic [3:0] be_n
);

    // Byte 0 of a word sits on lane 3, the most significant lane
    always_comb begin
        be_n = ebcu_pkg::BE_RST;
        case (width)
            ebcu_pkg::EBCU_W32: begin
                if (rd || size == ebcu_pkg::SIZE_WORD) begin
                    be_n = 4'h0;
                end else if (size == ebcu_pkg::SIZE_HALF) begin
                    be_n = lo[1] ? 4'hC : 4'h3;
                end else begin
                    be_n = ~(4'h8 >> lo);
                end
            end
            ebcu_pkg::EBCU_W16: begin
                // Lane 2 carries address bit 1, lane 3 is held low
                be_n[3] = 1'b0;
                be_n[2] = lo[1];
                if (rd || size != ebcu_pkg::SIZE_BYTE) begin
                    be_n[1:0] = 2'h0;
                end else begin
                    be_n[1:0] = lo[0] ? 2'h2 : 2'h1;
                end
            end
            ebcu_pkg::EBCU_W8: begin
                // Lanes 1 and 0 have no meaning here; parked high
                be_n = {lo[0], lo[1], 2'h3};
            end
            default: be_n = ebcu_pkg::BE_RST;
        endcase
    end

endmodule : ebcu_lane_steer

// ### ebcu_top.sv
// External bus cycle unit: sequences core requests onto the memory bus
`timescale 1ns/10ps
module ebcu_top (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Core request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_rd,
    input wire logic req_atomic,
    input wire logic req_instr,
    input wire logic req_burst,
    input wire logic [1:0] req_size,
    input wire logic [2:0] req_region,
    input wire logic [27:0] req_addr,
    input wire logic [3:0] req_asi,
    input wire logic [31:0] req_wdata,
    // Core response
    output logic rsp_valid,
    output logic rsp_err,
    output logic [31:0] rsp_rdata,
    output logic instr_exc,
    output logic data_exc,
    // Core demand status
    input wire logic wbuf_full,
    input wire logic fetch_pending,
    // Configuration levels
    input wire logic [5:1] region_width_code_hi,
    input wire logic [5:1] region_width_code_lo,
    input wire logic [5:0] wait_gen_en,
    input wire logic dram_enable,
    input wire logic dram_bus_16,
    input wire logic burst_enable,
    input wire logic hyperpage_enable,
    input wire logic dram_burst_enable,
    // Status levels
    output logic width_illegal,
    output logic edo_burst_mode,
    output logic page_mode_timing,
    // Boot width straps
    input wire logic boot_width_strap_byte,
    input wire logic boot_width_strap_half,
    // Memory bus control, floated under grant
    output logic address_strobe_n,
    output logic read_not_write,
    output logic lock_n,
    output logic [27:2] address,
    output logic [3:0] space_identifier,
    output logic [3:0] byte_lane_enable_n,
    output logic bus_oe_n,
    // Memory bus data
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic data_oe_n,
    // Memory bus responses
    input wire logic ready_n,
    input wire logic memory_error_n,
    output logic burst_offer_n,
    input wire logic burst_accept_n,
    // Arbitration
    input wire logic ext_bus_request_n,
    output logic ext_bus_grant_n,
    output logic cpu_bus_pending_n
);

    // Sequencer and transfer state
    ebcu_pkg::ebcu_state_t st_r, st_nxt;
    ebcu_pkg::ebcu_width_t width_r, width_nxt; // Width of the active region
    ebcu_pkg::ebcu_width_t boot_w_r, boot_w_nxt; // Boot width caught at reset
    logic boot_ill_r, boot_ill_nxt;
    logic [27:0] addr_r, addr_nxt; // Request address
    logic [3:0] asi_r, asi_nxt;
    logic [31:0] wdata_r, wdata_nxt; // Store data, lane aligned
    logic [1:0] size_r, size_nxt;
    logic rd_r, rd_nxt; // Current phase reads
    logic instr_r, instr_nxt;
    logic lock_r, lock_nxt; // Atomic sequence in progress
    logic burst_r, burst_nxt; // Burst offered on this cycle
    logic bursting_r, bursting_nxt; // Burst offered, then accepted by memory
    logic [1:0] lo_r, lo_nxt; // Byte offset of the current beat
    logic [1:0] beat_r, beat_nxt;
    logic [1:0] last_r, last_nxt; // Index of the final beat
    logic [2:0] ws_r, ws_nxt; // Internal wait-state countdown
    logic ws_en_r, ws_en_nxt;
    logic [31:0] rdata_r, rdata_nxt; // Read word under assembly
    logic [31:0] dout_r, dout_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic rsp_err_r, rsp_err_nxt;
    logic [31:0] rsp_rdata_r, rsp_rdata_nxt;
    logic iexc_r, iexc_nxt;
    logic dexc_r, dexc_nxt;
    logic [3:0] be_r;
    logic [3:0] be_nxt;

    // Region width lookup
    ebcu_pkg::ebcu_width_t strap_w, code_w, region_w;
    logic strap_ill, code_ill;
    logic [1:0] region_code;
    logic ready_eff; // Ready from the pin or the wait-state generator
    logic mem_err;

    // Boot strap pair decode
    ebcu_width_dec #(
        .STRAP(1'b1)
    ) u_strap_dec (
        .code({boot_width_strap_half, boot_width_strap_byte}),
        .width(strap_w),
        .illegal(strap_ill)
    );

    // Code of the requested region; the boot region has no code
    always_comb begin
        region_code = ebcu_pkg::CODE_W32;
        if (req_region != ebcu_pkg::REGION_BOOT && req_region < 3'(ebcu_pkg::REGION_COUNT)) begin
            region_code = {region_width_code_hi[req_region], region_width_code_lo[req_region]};
        end
    end

    // Region code decode
    ebcu_width_dec #(
        .STRAP(1'b0)
    ) u_code_dec (
        .code(region_code),
        .width(code_w),
        .illegal(code_ill)
    );

    // Final width, with DRAM regions following the DRAM bus width
    always_comb begin
        region_w = code_w;
        if (req_region == ebcu_pkg::REGION_BOOT) begin
            region_w = boot_w_r;
        end else if (dram_enable && (req_region == ebcu_pkg::REGION_DRAM_A
                                     || req_region == ebcu_pkg::REGION_DRAM_B)) begin
            region_w = dram_bus_16 ? ebcu_pkg::EBCU_W16 : ebcu_pkg::EBCU_W32;
        end
    end

    // Lane enables for the next beat, registered with the beat
    ebcu_lane_steer u_steer (
        .width(width_nxt),
        .rd(rd_nxt),
        .size(size_nxt),
        .lo(lo_nxt),
        .be_n(be_nxt)
    );

    // Ready qualification; error always comes from the pin
    always_comb begin
        mem_err = !memory_error_n;
        if (ws_en_r) begin
            ready_eff = (ws_r == 3'h0) || mem_err;
        end else begin
            ready_eff = !ready_n;
        end
    end

    // Core may hand over a request only while the bus is ours and idle
    assign req_ready = ce && st_r == ebcu_pkg::S_IDLE && ext_bus_request_n;

    // Sequencer next state
    always_comb begin
        st_nxt = st_r;
        width_nxt = width_r;
        boot_w_nxt = boot_w_r;
        boot_ill_nxt = boot_ill_r;
        addr_nxt = addr_r;
        asi_nxt = asi_r;
        wdata_nxt = wdata_r;
        size_nxt = size_r;
        rd_nxt = rd_r;
        instr_nxt = instr_r;
        lock_nxt = lock_r;
        burst_nxt = 1'b0;
        bursting_nxt = bursting_r;
        lo_nxt = lo_r;
        beat_nxt = beat_r;
        last_nxt = last_r;
        ws_nxt = (ws_r != 3'h0) ? ws_r - 3'h1 : ws_r;
        ws_en_nxt = ws_en_r;
        rdata_nxt = rdata_r;
        rsp_valid_nxt = 1'b0;
        rsp_err_nxt = 1'b0;
        rsp_rdata_nxt = rsp_rdata_r;
        iexc_nxt = 1'b0;
        dexc_nxt = 1'b0;
        if (!rst_n) begin
            // Straps are sampled while reset is held
            boot_w_nxt = strap_w;
            boot_ill_nxt = strap_ill;
        end
        case (st_r)
            ebcu_pkg::S_IDLE: begin
                if (!ext_bus_request_n) begin
                    st_nxt = ebcu_pkg::S_GRANT;
                end else if (req_valid) begin
                    st_nxt = ebcu_pkg::S_ADDR;
                    addr_nxt = req_addr;
                    asi_nxt = req_asi;
                    wdata_nxt = req_wdata;
                    size_nxt = req_size;
                    instr_nxt = req_instr;
                    width_nxt = region_w;
                    ws_en_nxt = wait_gen_en[req_region];
                    lock_nxt = req_atomic;
                    rd_nxt = req_rd || req_atomic;
                    beat_nxt = 2'h0;
                    bursting_nxt = 1'b0;
                    if (req_rd || req_atomic) begin
                        // Reads always move a whole word from offset 0
                        lo_nxt = 2'h0;
                        case (region_w)
                            ebcu_pkg::EBCU_W8: last_nxt = 2'h3;
                            ebcu_pkg::EBCU_W16: last_nxt = 2'h1;
                            default: last_nxt = 2'h0;
                        endcase
                        burst_nxt = burst_enable && req_burst && !req_atomic
                                    && region_w == ebcu_pkg::EBCU_W32;
                    end else begin
                        lo_nxt = req_addr[1:0];
                        last_nxt = 2'h0;
                        if (region_w == ebcu_pkg::EBCU_W16 && req_size == ebcu_pkg::SIZE_WORD) begin
                            last_nxt = 2'h1;
                        end else if (region_w == ebcu_pkg::EBCU_W8) begin
                            if (req_size == ebcu_pkg::SIZE_WORD) begin
                                last_nxt = 2'h3;
                            end else if (req_size == ebcu_pkg::SIZE_HALF) begin
                                last_nxt = 2'h1;
                            end
                        end
                    end
                end
            end
            ebcu_pkg::S_ADDR: begin
                // Strobe stands for this one cycle only
                st_nxt = ebcu_pkg::S_WAIT;
                ws_nxt = ebcu_pkg::WS_CYCLES;
                // The offer pulse is gone by the first ready, so remember it
                bursting_nxt = burst_r;
            end
            ebcu_pkg::S_WAIT: begin
                if (ready_eff && mem_err) begin
                    // Data is dropped; an atomic write is abandoned
                    st_nxt = ebcu_pkg::S_IDLE;
                    lock_nxt = 1'b0;
                    rsp_valid_nxt = 1'b1;
                    rsp_err_nxt = 1'b1;
                    iexc_nxt = rd_r && instr_r;
                    dexc_nxt = !(rd_r && instr_r);
                end else if (ready_eff) begin
                    if (beat_r == 2'h0 && bursting_r) begin
                        // Accept is looked at with the first word only
                        bursting_nxt = !burst_accept_n;
                    end
                    if (rd_r) begin
                        case (width_r)
                            ebcu_pkg::EBCU_W8: rdata_nxt = {rdata_r[23:0], data_in[31:24]};
                            ebcu_pkg::EBCU_W16: rdata_nxt = {rdata_r[15:0], data_in[31:16]};
                            default: rdata_nxt = data_in;
                        endcase
                    end
                    if (rd_r && (bursting_nxt || width_r == ebcu_pkg::EBCU_W32)) begin
                        // Each burst word is handed back as it lands
                        rsp_valid_nxt = 1'b1;
                        rsp_rdata_nxt = data_in;
                    end else if (rd_r && beat_r == last_r) begin
                        rsp_valid_nxt = 1'b1;
                        rsp_rdata_nxt = rdata_nxt;
                    end else if (!rd_r && beat_r == last_r) begin
                        rsp_valid_nxt = 1'b1;
                    end
                    if (bursting_nxt && beat_r != ebcu_pkg::BURST_LAST) begin
                        // Further words need no new strobe
                        beat_nxt = beat_r + 2'h1;
                        ws_nxt = ebcu_pkg::WS_CYCLES;
                    end else if (beat_r != last_r && !bursting_nxt) begin
                        beat_nxt = beat_r + 2'h1;
                        if (rd_r) begin
                            ws_nxt = ebcu_pkg::WS_CYCLES;
                            lo_nxt = (width_r == ebcu_pkg::EBCU_W8) ? lo_r + 2'h1 : lo_r + 2'h2;
                        end else begin
                            // Each store part is its own strobed transaction
                            st_nxt = ebcu_pkg::S_ADDR;
                            lo_nxt = (width_r == ebcu_pkg::EBCU_W8) ? lo_r + 2'h1 : lo_r + 2'h2;
                        end
                    end else if (lock_r && rd_r) begin
                        // One dead cycle turns the data bus around
                        st_nxt = ebcu_pkg::S_TURN;
                    end else begin
                        st_nxt = ebcu_pkg::S_IDLE;
                        lock_nxt = 1'b0;
                        bursting_nxt = 1'b0;
                    end
                end
            end
            ebcu_pkg::S_TURN: begin
                // Write half of the atomic pair, lock still held
                st_nxt = ebcu_pkg::S_ADDR;
                rd_nxt = 1'b0;
                beat_nxt = 2'h0;
                lo_nxt = addr_r[1:0];
                last_nxt = 2'h0;
                if (width_r == ebcu_pkg::EBCU_W16 && size_r == ebcu_pkg::SIZE_WORD) begin
                    last_nxt = 2'h1;
                end else if (width_r == ebcu_pkg::EBCU_W8 && size_r == ebcu_pkg::SIZE_WORD) begin
                    last_nxt = 2'h3;
                end else if (width_r == ebcu_pkg::EBCU_W8 && size_r == ebcu_pkg::SIZE_HALF) begin
                    last_nxt = 2'h1;
                end
            end
            ebcu_pkg::S_GRANT: begin
                if (ext_bus_request_n) begin
                    st_nxt = ebcu_pkg::S_IDLE;
                end
            end
            default: st_nxt = ebcu_pkg::S_IDLE;
        endcase
        // Store data placed on the upper lanes for narrow regions
        case (width_nxt)
            ebcu_pkg::EBCU_W8: dout_nxt = {wdata_nxt[31 - 8 * lo_nxt -: 8], 24'h000000};
            ebcu_pkg::EBCU_W16: dout_nxt = {lo_nxt[1] ? wdata_nxt[15:0] : wdata_nxt[31:16],
                                            16'h0000};
            default: dout_nxt = wdata_nxt;
        endcase
    end

    // Sequencer registers; reset acts even with the clock enable low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= ebcu_pkg::S_IDLE;
            width_r <= ebcu_pkg::EBCU_W32;
            addr_r <= ebcu_pkg::ADDR_RST;
            asi_r <= 4'h0;
            wdata_r <= ebcu_pkg::DATA_RST;
            size_r <= ebcu_pkg::SIZE_WORD;
            rd_r <= 1'b1;
            instr_r <= 1'b0;
            lock_r <= 1'b0;
            burst_r <= 1'b0;
            bursting_r <= 1'b0;
            lo_r <= 2'h0;
            beat_r <= 2'h0;
            last_r <= 2'h0;
            ws_r <= 3'h0;
            ws_en_r <= 1'b0;
            rdata_r <= ebcu_pkg::DATA_RST;
            dout_r <= ebcu_pkg::DATA_RST;
            be_r <= ebcu_pkg::BE_RST;
            rsp_valid_r <= 1'b0;
            rsp_err_r <= 1'b0;
            rsp_rdata_r <= ebcu_pkg::DATA_RST;
            iexc_r <= 1'b0;
            dexc_r <= 1'b0;
            boot_w_r <= boot_w_nxt;
            boot_ill_r <= boot_ill_nxt;
        end else if (ce) begin
            st_r <= st_nxt;
            width_r <= width_nxt;
            addr_r <= addr_nxt;
            asi_r <= asi_nxt;
            wdata_r <= wdata_nxt;
            size_r <= size_nxt;
            rd_r <= rd_nxt;
            instr_r <= instr_nxt;
            lock_r <= lock_nxt;
            burst_r <= burst_nxt;
            bursting_r <= bursting_nxt;
            lo_r <= lo_nxt;
            beat_r <= beat_nxt;
            last_r <= last_nxt;
            ws_r <= ws_nxt;
            ws_en_r <= ws_en_nxt;
            rdata_r <= rdata_nxt;
            dout_r <= dout_nxt;
            be_r <= be_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_err_r <= rsp_err_nxt;
            rsp_rdata_r <= rsp_rdata_nxt;
            iexc_r <= iexc_nxt;
            dexc_r <= dexc_nxt;
            boot_w_r <= boot_w_nxt;
            boot_ill_r <= boot_ill_nxt;
        end
    end

    // Bus pin drive; all drivers float while the other master owns the bus
    always_comb begin
        address_strobe_n = !(st_r == ebcu_pkg::S_ADDR);
        read_not_write = rd_r;
        lock_n = !lock_r;
        // Burst words walk bits 3:2 as start XOR beat; narrow parts keep the word
        address = {addr_r[27:4], addr_r[3:2] ^ (bursting_r ? beat_r : 2'h0)};
        space_identifier = asi_r;
        byte_lane_enable_n = be_r;
        bus_oe_n = (st_r == ebcu_pkg::S_GRANT);
        data_out = dout_r;
        data_oe_n = !(!rd_r && (st_r == ebcu_pkg::S_ADDR || st_r == ebcu_pkg::S_WAIT));
        burst_offer_n = !burst_r;
        ext_bus_grant_n = !(st_r == ebcu_pkg::S_GRANT);
        cpu_bus_pending_n = !(wbuf_full || fetch_pending);
        width_illegal = boot_ill_r || code_ill;
        edo_burst_mode = hyperpage_enable && dram_burst_enable;
        page_mode_timing = !(hyperpage_enable && dram_burst_enable);
    end

    // Core response outputs
    assign rsp_valid = rsp_valid_r;
    assign rsp_err = rsp_err_r;
    assign rsp_rdata = rsp_rdata_r;
    assign instr_exc = iexc_r;
    assign data_exc = dexc_r;

endmodule : ebcu_top

// ### ebcu_top_chk.sv
// Port assertions of the bus cycle unit
`timescale 1ns/10ps
module ebcu_top_chk (
    // Watched ports
    input wire logic mclk, rst_n, ce, address_strobe_n, read_not_write, data_oe_n, rsp_valid,
    input wire logic rsp_err, instr_exc, data_exc, wbuf_full, fetch_pending, cpu_bus_pending_n,
    input wire logic ext_bus_request_n, ext_bus_grant_n, bus_oe_n, hyperpage_enable,
    input wire logic dram_burst_enable, edo_burst_mode, page_mode_timing
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Master has dropped its request while it holds the bus
    sequence s_rel; ce && !ext_bus_grant_n && ext_bus_request_n; endsequence
    AST_STB: assert property (!address_strobe_n |=> address_strobe_n) else $error("strobe");
    AST_WR: assert property (!address_strobe_n && !read_not_write |-> !data_oe_n)
        else $error("write data");
    AST_ERR: assert property (rsp_err |-> rsp_valid && (instr_exc || data_exc))
        else $error("exception");
    AST_FLT: assert property (!ext_bus_grant_n |-> bus_oe_n) else $error("float");
    AST_GNT: assert property ($fell(ext_bus_grant_n) |-> !$past(ext_bus_request_n))
        else $error("grant");
    AST_REL: assert property (s_rel |=> ext_bus_grant_n) else $error("release");
    AST_PND: assert property (cpu_bus_pending_n == !(wbuf_full || fetch_pending))
        else $error("pending");
    AST_EDO: assert property (edo_burst_mode == (hyperpage_enable && dram_burst_enable))
        else $error("edo");
    AST_PGM: assert property (page_mode_timing == !(hyperpage_enable && dram_burst_enable))
        else $error("page mode");
endmodule : ebcu_top_chk

bind ebcu_top ebcu_top_chk ebcu_top_chk_inst (.*);

// ### ebcu_mem_model.sv
// Memory partner model
`timescale 1ns/10ps
module ebcu_mem_model (
    // Unit side and bench knobs
    input wire logic mclk, address_strobe_n, err, bacc,
    input wire logic [27:2] address,
    input wire logic [2:0] beats,
    input wire logic [1:0] wc,
    // Answers
    output logic ready_n = 1'b1, memory_error_n = 1'b1, burst_accept_n = 1'b1,
    output logic [31:0] data_in = 32'h0
);
    logic [2:0] left = 3'h0;  // Readies owed
    logic [1:0] cnt = 2'h0;  // Waits before next ready
    logic [27:2] err_addr = 26'h0;  // Failing address kept for recovery
    wire logic [31:0] val = {4'hA, address, left[1:0]};
    // One-cycle answers; idle data inverted so stale values never match
    always @(posedge mclk) begin
        ready_n <= 1'b1;
        memory_error_n <= 1'b1;
        burst_accept_n <= 1'b1;
        data_in <= ~val;
        if (!address_strobe_n) begin
            left <= beats;
            cnt <= wc;
        end else if (left != 3'h0 && cnt != 2'h0) begin  // Slow memory
            cnt <= cnt - 2'h1;
        end else if (left != 3'h0) begin
            ready_n <= 1'b0;
            memory_error_n <= !err;
            if (err) err_addr <= address;
            burst_accept_n <= !(bacc && left == beats);
            data_in <= val;
            left <= left - 3'h1;
            cnt <= wc;
        end
    end
endmodule : ebcu_mem_model

// ### ebcu_top_bench.sv
// Random bench of the bus cycle unit
`timescale 1ns/10ps
module ebcu_top_bench;
    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, req_valid = 1'b0, req_rd = 1'b1, req_atomic = 1'b0;
    logic req_instr = 1'b0, req_burst = 1'b0, wbuf_full = 1'b0, fetch_pending = 1'b0, err = 1'b0;
    logic dram_enable = 1'b0, dram_bus_16 = 1'b0, burst_enable = 1'b0, hyperpage_enable = 1'b0;
    logic dram_burst_enable = 1'b0, boot_width_strap_byte = 1'b1, boot_width_strap_half = 1'b1;
    logic ext_bus_request_n = 1'b1, bacc = 1'b0, req_ready, rsp_valid, rsp_err, instr_exc;
    logic data_exc, width_illegal, edo_burst_mode, page_mode_timing, address_strobe_n, lock_n;
    logic read_not_write, bus_oe_n, data_oe_n, ext_bus_grant_n, cpu_bus_pending_n, burst_offer_n;
    logic ready_n, memory_error_n, burst_accept_n, tk, srw, slk, sbo;
    logic [1:0] req_size = 2'h2, wc = 2'h0;
    logic [2:0] req_region = 3'h0, beats = 3'h1, ex;
    logic [3:0] req_asi = 4'h0, space_identifier, byte_lane_enable_n, sbe, ssi;
    logic [5:1] region_width_code_hi = 5'h0A, region_width_code_lo = 5'h0C;
    logic [5:0] wait_gen_en = 6'h00;
    logic [27:0] req_addr = 28'h0, a;
    logic [27:2] address;
    logic [31:0] req_wdata = 32'h0, rsp_rdata, data_in, data_out, rd, sdo;
    integer seed = 80813, n_mismatch = 0, compares = 0, i, k, n, ns, o;
    ebcu_top ebcu_top_inst (.*);
    ebcu_mem_model ebcu_mem_model_inst (.*);
    always #25 mclk = ~mclk;
    // Strobe cycles, sampled where outputs have settled
    always @(negedge mclk) if (!address_strobe_n) begin
        ns++; sbe = byte_lane_enable_n; srw = read_not_write; sdo = data_out; slk = lock_n;
        sbo = burst_offer_n;
        ssi = space_identifier;
    end
    task chk(input string nm, input logic [43:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task summarize;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    // One core request, held until taken, then followed to its last answer
    task run(input logic r, at, ins, bu, input logic [2:0] rg);
        {req_rd, req_atomic, req_instr, req_burst, req_region} = {r, at, ins, bu, rg};
        {wbuf_full, fetch_pending} = 2'($random(seed));
        req_addr = a; req_asi = 4'($random(seed)); req_valid = 1'b1; n = 0; ns = 0;
        for (i = 0; i < 300; i++) begin
            tk = req_ready === 1'b1;
            @(negedge mclk);
            if (tk) req_valid = 1'b0;
            if (rsp_valid === 1'b1) begin n++; rd = rsp_rdata; ex = {rsp_err, instr_exc, data_exc}; end
            if (n > 0 && req_ready === 1'b1) break;
        end
        if (i == 300) begin chk("timeout", 44'h0, 44'h1); summarize; end
    endtask : run
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        for (k = 0; k < 5; k++) begin
            req_region = 3'(k); @(negedge mclk);
            chk("illegal", width_illegal, k == 4);
        end
        for (k = 0; k < 4; k++) begin
            a = 28'($random(seed)) & 28'hFFFFFFC; req_wdata = $random(seed); beats = 3'h1;
            {hyperpage_enable, dram_burst_enable, dram_bus_16, burst_enable, wc} = 6'($random(seed));
            req_size = 2'h2; run(1, 0, 0, 0, 3'h1);
            chk("rd32", {ns[3:0], srw, sbe, rd}, {4'h1, 5'h10, 4'hA, a[27:2], 2'h1});
            run(0, 0, 0, 0, 3'h1); chk("wr32", {ns[3:0], srw, sbe, sdo}, {9'h020, req_wdata});
            run(0, 0, 0, 0, 3'h2); chk("wr16", {ns[3:0], sbe, sdo[31:16]}, {8'h24, req_wdata[15:0]});
            run(0, 1, 0, 0, 3'h1); chk("atomic", {ns[3:0], slk, ssi}, {5'h04, req_asi});
            beats = 3'h2; {dram_enable, dram_bus_16} = 2'h3; run(1, 0, 0, 0, 3'h4);
            chk("rd16", {ns[3:0], sbe, rd}, {8'h10, {2{4'hA, a[27:16]}}});
            beats = 3'h4; run(1, 0, 0, 0, 3'h3);
            chk("rd8", {ns[3:0], sbe[3:2], rd}, {6'h04, {4{4'hA, a[27:24]}}});
            beats = 3'h1; a[1:0] = 2'h0;
            for (o = 0; o < 3; o++) begin
                req_size = 2'(o); run(0, 0, 0, 0, 3'h3); n = (1 << o) - 1;
                chk("wr8", {ns[3:0], sbe[3:2], sdo[31:24]}, {4'(n + 1), n[0], n[1], req_wdata[31 - 8 * n -: 8]});
            end
            err = 1'b1; run(1, 0, 1, 0, 3'h1); chk("ierr", ex, 3'h6);
            req_size = 2'h2; run(0, 0, 0, 0, 3'h1); chk("werr", ex, 3'h5);
            chk("erraddr", ebcu_mem_model_inst.err_addr, a[27:2]);
            err = 1'b0; bacc = 1'b1; wc = 2'h1; beats = 3'h4; burst_enable = 1'b1;
            run(1, 0, 0, 1, 3'h1); bacc = 1'b0; chk("offer", sbo, 1'b0);
            chk("burst", {n[3:0], rd}, {4'h4, 4'hA, a[27:4], a[3:2] ^ 2'h3, 2'h1});
        end
        ext_bus_request_n = 1'b0; repeat (2) @(negedge mclk);
        chk("grant", {ext_bus_grant_n, bus_oe_n}, 2'h1);
        ext_bus_request_n = 1'b1; repeat (2) @(negedge mclk);
        chk("release", ext_bus_grant_n, 1'b1);
        summarize;
    end
endmodule : ebcu_top_bench
